// >>> verilog/lgd_pkg.sv
// lgd_pkg: register map, field positions, reset values and decode constants
// for the global and dejitter configuration bank of the dual line interface.
// assumes an 8-bit host register port and two line channels.
package lgd_pkg;

  // register offsets (byte addresses on the host port)
  localparam logic [7:0] ADDR_DEVICE_REV  = 8'h00;
  localparam logic [7:0] ADDR_SOFT_RESET  = 8'h01;
  localparam logic [7:0] ADDR_CH1_IMP     = 8'h02;
  localparam logic [7:0] ADDR_CH1_DJ      = 8'h03;
  localparam logic [7:0] ADDR_GLOBAL_CFG  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_SOURCE  = 8'h21;
  localparam logic [7:0] ADDR_CH2_IMP     = 8'h22;
  localparam logic [7:0] ADDR_CH2_DJ      = 8'h23;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'h3E;
  localparam logic [7:0] ADDR_EVT_MASK    = 8'h3F;

  // revision code; the value is arbitrary
  localparam logic [7:0] DEVICE_REV_VAL   = 8'h5A;

  // global configuration fields
  localparam int GCF_MON_HI   = 7;
  localparam int GCF_MON_LO   = 6;
  localparam int GCF_STD_BIT  = 4;
  localparam int GCF_COPY_BIT = 3;
  localparam int GCF_GATE_BIT = 2;
  localparam int GCF_PIN_HI   = 1;
  localparam int GCF_PIN_LO   = 0;
  localparam logic [7:0] GCF_WR_MASK = 8'hDF;  // bit 5 reserved
  localparam logic [7:0] GCF_RST     = 8'h04;  // gate closed

  // impedance configuration fields
  localparam int IMP_TX_HI = 5;
  localparam int IMP_TX_LO = 3;
  localparam int IMP_RX_HI = 2;
  localparam int IMP_RX_LO = 0;
  localparam logic [5:0] IMP_RST = 6'h00;

  // dejitter configuration fields
  localparam int DJ_LIMIT_BIT = 5;
  localparam int DJ_PLACE_HI  = 4;
  localparam int DJ_PLACE_LO  = 3;
  localparam int DJ_DEPTH_HI  = 2;
  localparam int DJ_DEPTH_LO  = 1;
  localparam int DJ_BW_BIT    = 0;
  localparam logic [5:0] DJ_RST = 6'h20;   // limit mode on

  // elastic store depths in bits
  localparam logic [7:0] DEPTH_LONG  = 8'h80;
  localparam logic [7:0] DEPTH_MID   = 8'h40;
  localparam logic [7:0] DEPTH_SHORT = 8'h20;

  // jitter corner frequencies in millihertz
  localparam logic [12:0] CORNER_E1_WIDE   = 13'h1A90;  // 6.8 Hz
  localparam logic [12:0] CORNER_T1_WIDE   = 13'h1388;  // 5 Hz
  localparam logic [12:0] CORNER_E1_NARROW = 13'h0384;  // 0.9 Hz
  localparam logic [12:0] CORNER_T1_NARROW = 13'h04E2;  // 1.25 Hz

  localparam logic [1:0] EVT_RST = 2'h0;

endpackage

// >>> verilog/lgd_regbank.sv
// lgd_regbank: global configuration, interrupt channel indication and
// per-channel impedance and dejitter configuration for a two-channel line
// interface. assumes a host port in the mclk_i domain (read data one cycle
// after the strobe) and per-channel pending interrupt levels from same-clock
// logic that already applies the per-source masks.
module lgd_regbank
  import lgd_pkg::*;
(
  input  logic        mclk_i,
  input  logic        arst_n_i,
  input  logic [7:0]  addr_i,
  input  logic [7:0]  wdata_i,
  input  logic        wr_i,
  input  logic        rd_i,
  output logic [7:0]  rdata_o,
  input  logic [1:0]  ch_irq_pend_i,
  output logic        irq_o,
  output logic        irq_oe_o,
  output logic        line_t1_o,
  output logic        mon_active_o,
  output logic        mon_tx_path_o,
  output logic [3:0]  tx_imp_int_o,
  output logic [1:0]  tx_imp_ext_o,
  output logic [3:0]  rx_imp_int_o,
  output logic [1:0]  rx_imp_ext_o,
  output logic [1:0]  dj_limit_o,
  output logic [1:0]  dj_in_tx_o,
  output logic [1:0]  dj_in_rx_o,
  output logic [15:0] dj_depth_o,
  output logic [25:0] dj_corner_mhz_o
);

  // elastic store depth from the two-bit depth code
  function automatic logic [7:0] depth_of(input logic [1:0] code);
    logic [7:0] d;
    d = DEPTH_SHORT;
    if (code == 2'b00)
    begin
      d = DEPTH_LONG;
    end
    else if (code == 2'b01)
    begin
      d = DEPTH_MID;
    end
    return d;
  endfunction

  // jitter corner from bandwidth bit and line standard
  function automatic logic [12:0] corner_of(input logic bw, input logic t1);
    logic [12:0] c;
    if (bw)
    begin
      c = t1 ? CORNER_T1_NARROW : CORNER_E1_NARROW;
    end
    else
    begin
      c = t1 ? CORNER_T1_WIDE : CORNER_E1_WIDE;
    end
    return c;
  endfunction

  logic [7:0] gcf_q;
  logic [5:0] imp_q [2];
  logic [5:0] dj_q  [2];
  logic [1:0] evt_q;
  logic [1:0] evt_mask_q;
  logic [1:0] pend_prev_q;
  logic [7:0] rdata_q;
  logic       irq_act_q;
  logic       irq_q;
  logic       irq_oe_q;
  logic       soft_rst;
  logic       copy_en;
  logic [1:0] wr_imp;
  logic [1:0] wr_dj;
  logic [1:0] evt_new;
  logic       irq_act_d;

  assign soft_rst = wr_i && (addr_i == ADDR_SOFT_RESET);
  assign copy_en  = gcf_q[GCF_COPY_BIT];

  // broadcast makes one write hit both channels
  assign wr_imp[0] = wr_i && ((addr_i == ADDR_CH1_IMP) || (copy_en && addr_i == ADDR_CH2_IMP));
  assign wr_imp[1] = wr_i && ((addr_i == ADDR_CH2_IMP) || (copy_en && addr_i == ADDR_CH1_IMP));
  assign wr_dj[0]  = wr_i && ((addr_i == ADDR_CH1_DJ) || (copy_en && addr_i == ADDR_CH2_DJ));
  assign wr_dj[1]  = wr_i && ((addr_i == ADDR_CH2_DJ) || (copy_en && addr_i == ADDR_CH1_DJ));

  // global configuration; reserved bit 5 is never stored
  // standard bit defaults to E1
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gcf_q <= GCF_RST;
    end
    else if (soft_rst)
    begin
      gcf_q <= GCF_RST;
    end
    else if (wr_i && addr_i == ADDR_GLOBAL_CFG)
    begin
      gcf_q <= wdata_i & GCF_WR_MASK;
    end
  end

  // per-channel impedance and dejitter registers
  // defaults restored by either reset
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        imp_q[c] <= IMP_RST;
        dj_q[c]  <= DJ_RST;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (soft_rst)
        begin
          imp_q[c] <= IMP_RST;
          dj_q[c]  <= DJ_RST;
        end
        else
        begin
          if (wr_imp[c])
          begin
            imp_q[c] <= wdata_i[5:0];
          end
          if (wr_dj[c])
          begin
            dj_q[c] <= wdata_i[5:0];
          end
        end
      end
    end
  end

  // sticky channel events: a new pending edge sets, write-one clears;
  // the set term is applied last so an event in the clear cycle survives
  assign evt_new = ch_irq_pend_i & ~pend_prev_q;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pend_prev_q <= 2'b00;
      evt_q       <= EVT_RST;
      evt_mask_q  <= EVT_RST;
    end
    else
    begin
      pend_prev_q <= ch_irq_pend_i;
      if (soft_rst)
      begin
        evt_q      <= evt_new;
        evt_mask_q <= EVT_RST;
      end
      else
      begin
        if (wr_i && addr_i == ADDR_EVT_STATUS)
        begin
          evt_q <= (evt_q & ~wdata_i[1:0]) | evt_new;
        end
        else
        begin
          evt_q <= evt_q | evt_new;
        end
        if (wr_i && addr_i == ADDR_EVT_MASK)
        begin
          evt_mask_q <= wdata_i[1:0];
        end
      end
    end
  end

  // interrupt request: gate open and a pending source
  assign irq_act_d = !gcf_q[GCF_GATE_BIT] &&
                     ((|ch_irq_pend_i) || (|(evt_q & evt_mask_q)));

  // pin style; open drain only pulls low, the wire idles high
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_act_q <= 1'b0;
      irq_q     <= 1'b0;
      irq_oe_q  <= 1'b0;
    end
    else
    begin
      irq_act_q <= irq_act_d;
      if (!gcf_q[GCF_PIN_LO])
      begin
        irq_q    <= 1'b0;
        irq_oe_q <= irq_act_d;
      end
      else if (gcf_q[GCF_PIN_HI])
      begin
        irq_q    <= irq_act_d;
        irq_oe_q <= 1'b1;
      end
      else
      begin
        irq_q    <= !irq_act_d;
        irq_oe_q <= 1'b1;
      end
    end
  end

  assign irq_o    = irq_q;
  assign irq_oe_o = irq_oe_q;

  // register read, data valid only in the cycle after the strobe
  // source indication is active low, reserved bits read 0
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= 8'h00;
    end
    else if (rd_i)
    begin
      unique case (addr_i)
        ADDR_DEVICE_REV: rdata_q <= DEVICE_REV_VAL;
        ADDR_GLOBAL_CFG: rdata_q <= gcf_q;
        ADDR_IRQ_SOURCE: rdata_q <= {6'h00, ~ch_irq_pend_i};
        ADDR_CH1_IMP:    rdata_q <= {2'b00, imp_q[0]};
        ADDR_CH2_IMP:    rdata_q <= {2'b00, imp_q[1]};
        ADDR_CH1_DJ:     rdata_q <= {2'b00, dj_q[0]};
        ADDR_CH2_DJ:     rdata_q <= {2'b00, dj_q[1]};
        ADDR_EVT_STATUS: rdata_q <= {6'h00, evt_q};
        ADDR_EVT_MASK:   rdata_q <= {6'h00, evt_mask_q};
        default:         rdata_q <= 8'h00;  // unmapped and write-only
      endcase
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;

  // decoded configuration to the datapath, registered so every data output
  // leaves a flop; costs one cycle of latency after a register write
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      line_t1_o       <= 1'b0;
      mon_active_o    <= 1'b0;
      mon_tx_path_o   <= 1'b0;
      tx_imp_int_o    <= 4'h0;
      tx_imp_ext_o    <= 2'b00;
      rx_imp_int_o    <= 4'h0;
      rx_imp_ext_o    <= 2'b00;
      dj_limit_o      <= 2'b11;
      dj_in_tx_o      <= 2'b00;
      dj_in_rx_o      <= 2'b00;
      dj_depth_o      <= {DEPTH_LONG, DEPTH_LONG};
      dj_corner_mhz_o <= {CORNER_E1_WIDE, CORNER_E1_WIDE};
    end
    else
    begin
      line_t1_o     <= gcf_q[GCF_STD_BIT];
      // monitor only for codes ending in 1
      mon_active_o  <= gcf_q[GCF_MON_LO];
      mon_tx_path_o <= gcf_q[GCF_MON_LO] & gcf_q[GCF_MON_HI];
      for (int c = 0; c < 2; c++)
      begin
        // internal matching code in the low two bits
        tx_imp_int_o[2*c +: 2] <= imp_q[c][IMP_TX_LO +: 2];
        rx_imp_int_o[2*c +: 2] <= imp_q[c][IMP_RX_LO +: 2];
        // external transmit resistors only honoured in E1
        tx_imp_ext_o[c] <= imp_q[c][IMP_TX_HI] & ~gcf_q[GCF_STD_BIT];
        rx_imp_ext_o[c] <= imp_q[c][IMP_RX_HI];
        dj_limit_o[c] <= dj_q[c][DJ_LIMIT_BIT];
        dj_in_tx_o[c] <= dj_q[c][DJ_PLACE_LO] & ~dj_q[c][DJ_PLACE_HI];
        dj_in_rx_o[c] <= dj_q[c][DJ_PLACE_LO] & dj_q[c][DJ_PLACE_HI];
        dj_depth_o[8*c +: 8] <= depth_of(dj_q[c][DJ_DEPTH_HI:DJ_DEPTH_LO]);
        dj_corner_mhz_o[13*c +: 13] <= corner_of(dj_q[c][DJ_BW_BIT], gcf_q[GCF_STD_BIT]);
      end
    end
  end

  // ---- assertions ----

  property p_gate_blocks;
    @(posedge mclk_i) disable iff (!arst_n_i)
    gcf_q[GCF_GATE_BIT] |=> !irq_act_q;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks)
    else $error("interrupt raised while global gate closed");

  property p_gate_open_irq;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (!gcf_q[GCF_GATE_BIT] && (|ch_irq_pend_i)) |=> irq_act_q;
  endproperty
  a_gate_open_irq: assert property (p_gate_open_irq)
    else $error("pending channel did not raise interrupt");

  property p_irq_drops;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (ch_irq_pend_i == 2'b00 && (evt_q & evt_mask_q) == 2'b00) |=> !irq_act_q;
  endproperty
  a_irq_drops: assert property (p_irq_drops)
    else $error("interrupt held with nothing pending");

  property p_open_drain;
    @(posedge mclk_i) disable iff (!arst_n_i)
    !gcf_q[GCF_PIN_LO] ##1 $stable(gcf_q) |-> (irq_oe_o == irq_act_q) && !irq_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin style wrong");

  property p_push_high;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (gcf_q[GCF_PIN_HI:GCF_PIN_LO] == 2'b11) ##1 $stable(gcf_q)
      |-> irq_oe_o && (irq_o == irq_act_q);
  endproperty
  a_push_high: assert property (p_push_high)
    else $error("push-pull active high pin style wrong");

  property p_broadcast;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == ADDR_CH1_DJ && copy_en) |=> dj_q[1] == $past(wdata_i[5:0]);
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("broadcast write missed second channel");

  property p_no_broadcast;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == ADDR_CH1_IMP && !copy_en) |=> $stable(imp_q[1]);
  endproperty
  a_no_broadcast: assert property (p_no_broadcast)
    else $error("write leaked to other channel");

  property p_soft_reset;
    @(posedge mclk_i) disable iff (!arst_n_i)
    soft_rst |=> gcf_q == GCF_RST && dj_q[0] == DJ_RST && imp_q[1] == IMP_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset did not restore defaults");

  property p_source_read;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == ADDR_IRQ_SOURCE) |=> rdata_o == {6'h00, ~$past(ch_irq_pend_i)};
  endproperty
  a_source_read: assert property (p_source_read)
    else $error("source indication read wrong");

  property p_ext_tx_t1;
    @(posedge mclk_i) disable iff (!arst_n_i)
    gcf_q[GCF_STD_BIT] ##1 gcf_q[GCF_STD_BIT] |-> tx_imp_ext_o == 2'b00;
  endproperty
  a_ext_tx_t1: assert property (p_ext_tx_t1)
    else $error("external transmit matching selected in T1 mode");

  property p_depth_short;
    @(posedge mclk_i) disable iff (!arst_n_i)
    dj_q[0][DJ_DEPTH_HI] |=> dj_depth_o[7:0] == DEPTH_SHORT;
  endproperty
  a_depth_short: assert property (p_depth_short)
    else $error("depth code 1x not 32 bits");

  property p_place_rx;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (dj_q[1][DJ_PLACE_HI:DJ_PLACE_LO] == 2'b11) |=> dj_in_rx_o[1] && !dj_in_tx_o[1];
  endproperty
  a_place_rx: assert property (p_place_rx)
    else $error("receive placement not decoded");

endmodule // lgd_regbank

// >>> test/lgd_host_model.sv
// lgd_host_model: host processor side of the register port of the bank.
// assumes the bank shares mclk_i; the bench calls the tasks below in turn.
module lgd_host_model
  import lgd_pkg::*;
(
  input  logic       mclk_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic       wr_o,
  output logic       rd_o,
  input  logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial
  begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // one-cycle write; a released bus shows the inverse, never a stale copy
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  // one-cycle read; data is taken in the single cycle where it stands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(negedge mclk_i);
    d = rdata_i;
  endtask

  task automatic soft_reset();
    wr_reg(ADDR_SOFT_RESET, 8'hA5);  // data is don't-care
  endtask
endmodule // lgd_host_model

// >>> test/test_lgd_regbank.sv
// test_lgd_regbank: self-checking bench for the configuration bank.
// assumes one 100 MHz clock and the host model on the register port.
module test_lgd_regbank
  import lgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr, wdata, rdata;
  logic        wr_stb, rd, irq, irq_oe, line_t1, mon_active, mon_tx;
  logic [1:0]  pend = 2'b00;
  logic [3:0]  tx_int, rx_int;
  logic [1:0]  tx_ext, rx_ext, dj_limit, dj_in_tx, dj_in_rx;
  logic [15:0] dj_depth;
  logic [25:0] dj_corner;
  int          err_count = 0;
  int          tests_run = 0;

  // free-running clock
  always #5 mclk = ~mclk;

  lgd_regbank u_lgd_regbank (
    .mclk_i(mclk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_stb), .rd_i(rd), .rdata_o(rdata), .ch_irq_pend_i(pend),
    .irq_o(irq), .irq_oe_o(irq_oe), .line_t1_o(line_t1),
    .mon_active_o(mon_active), .mon_tx_path_o(mon_tx),
    .tx_imp_int_o(tx_int), .tx_imp_ext_o(tx_ext), .rx_imp_int_o(rx_int),
    .rx_imp_ext_o(rx_ext), .dj_limit_o(dj_limit), .dj_in_tx_o(dj_in_tx),
    .dj_in_rx_o(dj_in_rx), .dj_depth_o(dj_depth), .dj_corner_mhz_o(dj_corner));

  lgd_host_model u_lgd_host_model (
    .mclk_i(mclk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr_stb), .rd_o(rd),
    .rdata_i(rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_lgd_host_model.wr_reg(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_lgd_host_model.rd_reg(a, d);
    chk(32'(d), 32'(exp));
  endtask

  // decoded outputs lag the register by a cycle; wait past that
  task automatic settle();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask

  // expected {output enable, pin level} for a pin style and activity
  function automatic logic [1:0] exp_pin(input logic [1:0] s, input logic act);
    if (!s[0])
      return {act, 1'b0};
    return s[1] ? {1'b1, act} : {1'b1, ~act};
  endfunction

  task automatic t_reset();
    rd_chk(ADDR_GLOBAL_CFG, 8'h04);
    rd_chk(ADDR_CH1_IMP, 8'h00);
    rd_chk(ADDR_CH2_DJ, 8'h20);
    chk(32'(dj_limit), 32'(2'b11));
    chk(32'(dj_depth), 32'(16'h8080));
    chk(32'({irq_oe, irq}), 32'(2'b00));
    $display("test reset done");
  endtask

  task automatic t_global();
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      wr(ADDR_GLOBAL_CFG, {m, 6'h14});
      settle();
      chk(32'({mon_active, mon_tx}), 32'({m[0], m == 2'b11}));
      chk(32'(line_t1), 32'(1'b1));
    end
    wr(ADDR_GLOBAL_CFG, 8'hFF);
    rd_chk(ADDR_GLOBAL_CFG, 8'hDF);
    wr(ADDR_GLOBAL_CFG, 8'h04);
    settle();
    chk(32'(line_t1), 32'(1'b0));
    $display("test global done");
  endtask

  task automatic t_imp();
    logic [2:0] c;
    for (int s = 0; s < 2; s++)
    begin
      wr(ADDR_GLOBAL_CFG, {3'b000, 1'(s), 4'h4});
      for (int i = 0; i < 8; i++)
      begin
        c = 3'(i);
        wr(ADDR_CH1_IMP, {2'b00, c, ~c});
        settle();
        // inversions sit in a concatenation or use logical not so the
        // cast to 32 bits cannot widen them before they are inverted
        if (!c[2])
          chk(32'(tx_int[1:0]), 32'(c[1:0]));
        else
          chk(32'(rx_int[1:0]), 32'({~c[1:0]}));
        chk(32'(tx_ext[0]), 32'(c[2] & (s == 0)));
        chk(32'(rx_ext[0]), 32'(!c[2]));
        rd_chk(ADDR_CH1_IMP, {2'b00, c, ~c});
      end
    end
    $display("test impedance done");
  endtask

  task automatic t_dj();
    logic [5:0]  v;
    logic [12:0] cor;
    for (int s = 0; s < 2; s++)
    begin
      wr(ADDR_GLOBAL_CFG, {3'b000, 1'(s), 4'h4});
      for (int i = 0; i < 64; i++)
      begin
        v = 6'(i);
        wr(ADDR_CH1_DJ, {2'b00, v});
        settle();
        cor = v[0] ? (s == 1 ? CORNER_T1_NARROW : CORNER_E1_NARROW)
                   : (s == 1 ? CORNER_T1_WIDE : CORNER_E1_WIDE);
        chk(32'(dj_limit[0]), 32'(v[5]));
        chk(32'({dj_in_tx[0], dj_in_rx[0]}), 32'({v[4:3] == 2'b01, v[4:3] == 2'b11}));
        chk(32'(dj_depth[7:0]),
            32'(v[2] ? DEPTH_SHORT : v[1] ? DEPTH_MID : DEPTH_LONG));
        chk(32'(dj_corner[12:0]), 32'(cor));
      end
    end
    $display("test dejitter done");
  endtask

  task automatic t_copy();
    wr(ADDR_GLOBAL_CFG, 8'h04);
    wr(ADDR_CH1_IMP, 8'h09);
    wr(ADDR_CH2_IMP, 8'h12);
    rd_chk(ADDR_CH1_IMP, 8'h09);
    rd_chk(ADDR_CH2_IMP, 8'h12);
    // broadcast one way on each register pair: dejitter 1 to 2, impedance 2 to 1
    wr(ADDR_GLOBAL_CFG, 8'h0C);
    wr(ADDR_CH1_DJ, 8'h1B);
    wr(ADDR_CH2_IMP, 8'h2D);
    rd_chk(ADDR_CH2_DJ, 8'h1B);
    rd_chk(ADDR_CH1_DJ, 8'h1B);
    rd_chk(ADDR_CH1_IMP, 8'h2D);
    rd_chk(ADDR_CH2_IMP, 8'h2D);
    settle();
    chk(32'(dj_depth), 32'(16'h4040));
    chk(32'(dj_in_rx), 32'(2'b11));
    chk(32'({dj_limit, dj_in_tx}), 32'(4'h0));
    chk(32'(dj_corner), 32'({CORNER_E1_NARROW, CORNER_E1_NARROW}));
    // code 101 on both sides: internal code 01 kept, external chosen in E1
    chk(32'({tx_int, rx_int, tx_ext, rx_ext}), 32'(12'h55F));
    wr(ADDR_GLOBAL_CFG, 8'h04);
    $display("test broadcast done");
  endtask

  task automatic t_irq();
    wr(ADDR_GLOBAL_CFG, 8'h07);
    @(posedge mclk);
    pend <= 2'b01;
    settle();
    chk(32'({irq_oe, irq}), 32'(exp_pin(2'b11, 1'b0)));
    rd_chk(ADDR_IRQ_SOURCE, 8'h02);
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_GLOBAL_CFG, 8'(s));
      settle();
      chk(32'({irq_oe, irq}), 32'(exp_pin(2'(s), 1'b1)));
    end
    @(posedge mclk);
    pend <= 2'b10;
    settle();
    rd_chk(ADDR_IRQ_SOURCE, 8'h01);
    @(posedge mclk);
    pend <= 2'b00;
    wr(ADDR_EVT_STATUS, 8'h03);
    settle();
    chk(32'({irq_oe, irq}), 32'(exp_pin(2'b11, 1'b0)));
    @(posedge mclk);
    pend <= 2'b10;
    @(posedge mclk);
    pend <= 2'b00;
    rd_chk(ADDR_EVT_STATUS, 8'h02);
    settle();
    chk(32'({irq_oe, irq}), 32'(exp_pin(2'b11, 1'b0)));
    wr(ADDR_EVT_MASK, 8'h02);
    settle();
    chk(32'({irq_oe, irq}), 32'(exp_pin(2'b11, 1'b1)));
    wr(ADDR_EVT_STATUS, 8'h02);
    settle();
    chk(32'({irq_oe, irq}), 32'(exp_pin(2'b11, 1'b0)));
    $display("test interrupt done");
  endtask

  task automatic t_soft();
    wr(ADDR_GLOBAL_CFG, 8'h5B);
    wr(ADDR_CH1_DJ, 8'h0F);
    wr(ADDR_CH2_IMP, 8'h3F);
    wr(ADDR_IRQ_SOURCE, 8'h00);
    rd_chk(ADDR_IRQ_SOURCE, 8'h03);
    rd_chk(8'h40, 8'h00);
    rd_chk(ADDR_DEVICE_REV, DEVICE_REV_VAL);
    u_lgd_host_model.soft_reset();
    rd_chk(ADDR_GLOBAL_CFG, 8'h04);
    rd_chk(ADDR_CH1_DJ, 8'h20);
    rd_chk(ADDR_CH2_IMP, 8'h00);
    rd_chk(ADDR_EVT_MASK, 8'h00);
    rd_chk(ADDR_SOFT_RESET, 8'h00);
    settle();
    chk(32'({dj_limit, line_t1, mon_active}), 32'(4'b1100));
    $display("test soft reset done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // reset for two cycles, then run every scenario in turn
  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_global();
    t_imp();
    t_dj();
    t_copy();
    t_irq();
    t_soft();
    complete_run();
  end

  // the whole run needs about 900 cycles; a hang is cut well beyond
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_count++;
    complete_run();
  end
endmodule // test_lgd_regbank
